// file: hw/rops_consts.svh
// Constants for the remappable output pin select block.
`ifndef ROPS_CONSTS_SVH
`define ROPS_CONSTS_SVH
// ==========================================================
// Field layout and reset value
`define ROPS_SEL_W 6
`define ROPS_SEL_RESET 6'h00
// ==========================================================
// Output selection codes
`define ROPS_CODE_NULL 6'h00
`define ROPS_CODE_SER1_TX 6'h01
`define ROPS_CODE_SER2_TX 6'h03
`define ROPS_CODE_SPI2_DO 6'h08
`define ROPS_CODE_SPI2_CK 6'h09
`define ROPS_CODE_SPI2_SS 6'h0a
`define ROPS_CODE_CAN_TX 6'h0e
`define ROPS_CODE_OC1 6'h10
`define ROPS_CODE_OC4 6'h13
`define ROPS_CODE_CMP1 6'h18
`define ROPS_CODE_CMP2 6'h19
`define ROPS_CODE_CMP3 6'h1a
`define ROPS_CODE_PWM_SYNC 6'h2d
`define ROPS_CODE_ENC_CMP 6'h2f
`define ROPS_CODE_REFCLK 6'h31
`define ROPS_CODE_CMP4 6'h32
// ==========================================================
// Unlock key pair, written in order on the key port
`define ROPS_KEY1 8'h55
`define ROPS_KEY2 8'haa
`endif

// file: hw/rops_pkg.sv
// Types for the remappable output pin select block.
package rops_pkg;
   // Peripheral output signals offered to the crossbar.
   typedef struct packed {
      logic serial1_transmit;
      logic serial2_transmit;
      logic spi2_data_out;
      logic spi2_clock_out;
      logic spi2_select_out;
      logic can_transmit;
      logic [3:0] compare_out;
      logic [3:0] comparator_out;
      logic pwm_timebase_sync_out;
      logic encoder_count_compare_out;
      logic reference_clock_out;
   } rops_periph_t;
   // Lock state machine.
   typedef enum logic [2:0] {
      ROPS_LOCKED = 3'b001,
      ROPS_HALF = 3'b010,
      ROPS_OPEN = 3'b100
   } rops_lock_t;
endpackage

// file: hw/rops_pin_mux.sv
// One pin's output multiplexer and code decode stage.
`timescale 1ns/1ps
`include "rops_consts.svh"
module rops_pin_mux #(
   parameter bit HAS_CAN = 1'b1,
   parameter bit HAS_MC = 1'b1
) (
   input wire logic [5:0] sel,
   input wire rops_pkg::rops_periph_t periph,
   output logic drive_valid,
   output logic drive_level
);
   // ==========================================================
   // Code decode
   // Unknown codes and absent variant options fall to the null route.
   always_comb begin
      drive_valid = 1'b1;
      drive_level = 1'b0;
      if (sel == `ROPS_CODE_SER1_TX) begin // [RULE3]
         drive_level = periph.serial1_transmit;
      end else if (sel == `ROPS_CODE_SER2_TX) begin // [RULE3]
         drive_level = periph.serial2_transmit;
      end else if (sel == `ROPS_CODE_SPI2_DO) begin // [RULE4]
         drive_level = periph.spi2_data_out;
      end else if (sel == `ROPS_CODE_SPI2_CK) begin // [RULE4]
         drive_level = periph.spi2_clock_out;
      end else if (sel == `ROPS_CODE_SPI2_SS) begin // [RULE4]
         drive_level = periph.spi2_select_out;
      end else if (HAS_CAN && sel == `ROPS_CODE_CAN_TX) begin // [RULE5]
         drive_level = periph.can_transmit;
      end else if (sel >= `ROPS_CODE_OC1 && sel <= `ROPS_CODE_OC4) begin
         drive_level = periph.compare_out[sel[1:0]]; // [RULE6]
      end else if (sel == `ROPS_CODE_CMP1) begin // [RULE7]
         drive_level = periph.comparator_out[0];
      end else if (sel == `ROPS_CODE_CMP2) begin // [RULE7]
         drive_level = periph.comparator_out[1];
      end else if (sel == `ROPS_CODE_CMP3) begin // [RULE7]
         drive_level = periph.comparator_out[2];
      end else if (sel == `ROPS_CODE_CMP4) begin // [RULE7]
         drive_level = periph.comparator_out[3];
      end else if (HAS_MC && sel == `ROPS_CODE_PWM_SYNC) begin // [RULE8]
         drive_level = periph.pwm_timebase_sync_out;
      end else if (HAS_MC && sel == `ROPS_CODE_ENC_CMP) begin // [RULE8]
         drive_level = periph.encoder_count_compare_out;
      end else if (sel == `ROPS_CODE_REFCLK) begin // [RULE9]
         drive_level = periph.reference_clock_out;
      end else begin
         drive_valid = 1'b0; // [RULE19] [RULE2]
      end
   end
endmodule

// file: hw/rops_top.sv
// Remappable output pin select crossbar with write lock.
`timescale 1ns/1ps
`include "rops_consts.svh"
// Summary of operation
// RULE1: Each remappable pin owns a six-bit selector.
// RULE2: Selectors reset to zero, pin on default.
// RULE3: Codes 1 and 3 route serial transmits.
// RULE4: Codes 8 to 10 route SPI2 outputs.
// RULE5: Code 0x0E routes CAN transmit, if present.
// RULE6: Codes 0x10 to 0x13 route compares.
// RULE7: Comparators one to four on their codes.
// RULE8: Motor variants route PWM sync, encoder compare.
// RULE9: Code 0x31 routes the reference clock.
// RULE10: Remapped output overrides other digital functions.
// RULE11: Analog function always keeps the pin.
// RULE12: No lockouts between selectors at all.
// RULE13: Input-only pins never get remapped outputs.
// RULE14: Software maps remappable peripherals before use.
// RULE15: Fixed peripherals drive their default pin.
// RULE16: Input and output routing are independent.
// RULE17: Hardware guards mappings against spurious change.
// RULE18: Two-wire bus, PWM, analog never remapped.
// RULE19: Unassigned codes behave like code zero.
// RULE20: Writes need an explicit unlock sequence first.
module rops_top #(
   parameter int NUM_PINS = 8,
   parameter int NUM_INPUT_ONLY = 4,
   parameter bit HAS_CAN = 1'b1,
   parameter bit HAS_MC = 1'b1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic key_valid,
   input wire logic [7:0] key_data,
   input wire logic lock_req,
   input wire logic sel_write,
   input wire logic [7:0] sel_index,
   input wire logic [5:0] sel_data,
   input wire rops_pkg::rops_periph_t periph,
   input wire logic [NUM_PINS-1:0] default_valid,
   input wire logic [NUM_PINS-1:0] default_level,
   input wire logic [NUM_PINS-1:0] analog_sel,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_INPUT_ONLY-1:0] input_only_pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe,
   output logic [NUM_PINS-1:0] pin_in_sync,
   output logic [NUM_INPUT_ONLY-1:0] input_only_in_sync,
   output logic [NUM_PINS*6-1:0] sel_readback,
   output logic unlocked,
   output logic write_rejected
);
   // ==========================================================
   // Elaboration checks
   initial begin
      if (NUM_PINS < 1 || NUM_PINS > 256) begin
         $error("NUM_PINS must be between 1 and 256");
      end
      if (NUM_INPUT_ONLY < 1) begin
         $error("NUM_INPUT_ONLY must be at least 1");
      end
   end

   // ==========================================================
   // State
   typedef struct packed {
      rops_pkg::rops_lock_t lock;
      logic [NUM_PINS-1:0][5:0] sel;
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe;
      logic [NUM_PINS-1:0] in_s1;
      logic [NUM_PINS-1:0] in_s2;
      logic [NUM_INPUT_ONLY-1:0] io_s1;
      logic [NUM_INPUT_ONLY-1:0] io_s2;
      logic rejected;
   } rops_state_t;

   rops_state_t st;
   rops_state_t next_st;
   logic [NUM_PINS-1:0] mux_valid;
   logic [NUM_PINS-1:0] mux_level;

   // ==========================================================
   // Per-pin decoders
   // Every pin has its own decoder, so nothing ties two selectors.
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      rops_pin_mux #(
         .HAS_CAN(HAS_CAN),
         .HAS_MC(HAS_MC)
      ) u_mux (
         .sel(st.sel[p]),
         .periph(periph),
         .drive_valid(mux_valid[p]),
         .drive_level(mux_level[p])
      ); // [RULE1] [RULE12]
   end

   // ==========================================================
   // Next state
   // The second key must be the next key written, idle cycles between are allowed; any other key value relocks,
   // which keeps a runaway write loop from opening the gate by chance.
   always_comb begin
      next_st = st;
      next_st.rejected = 1'b0;
      case (st.lock)
         rops_pkg::ROPS_LOCKED: begin
            if (key_valid && key_data == `ROPS_KEY1) begin // [RULE20]
               next_st.lock = rops_pkg::ROPS_HALF;
            end
         end
         rops_pkg::ROPS_HALF: begin
            if (key_valid) begin
               if (key_data == `ROPS_KEY2) begin // [RULE20]
                  next_st.lock = rops_pkg::ROPS_OPEN;
               end else begin
                  next_st.lock = rops_pkg::ROPS_LOCKED;
               end
            end
         end
         rops_pkg::ROPS_OPEN: begin
            if (lock_req) begin
               next_st.lock = rops_pkg::ROPS_LOCKED;
            end
         end
         default: begin
            next_st.lock = rops_pkg::ROPS_LOCKED;
         end
      endcase
      // Writes land only while open; others are dropped and flagged.
      if (sel_write) begin
         if (st.lock == rops_pkg::ROPS_OPEN &&
             int'(sel_index) < NUM_PINS) begin // [RULE17]
            next_st.sel[sel_index] = sel_data; // [RULE12]
         end else begin
            next_st.rejected = 1'b1; // [RULE20]
         end
      end
      // Priority: analog first, then remap, then the default function.
      for (int p = 0; p < NUM_PINS; p++) begin
         if (analog_sel[p]) begin // [RULE11]
            next_st.oe[p] = 1'b0;
            next_st.out[p] = 1'b0;
         end else if (mux_valid[p]) begin // [RULE10]
            next_st.oe[p] = 1'b1;
            next_st.out[p] = mux_level[p];
         end else begin // [RULE15] [RULE18]
            next_st.oe[p] = default_valid[p];
            next_st.out[p] = default_level[p] & default_valid[p];
         end
      end
      // Pin inputs go to the separate input routing, synchronised.
      next_st.in_s1 = pin_in; // [RULE16]
      next_st.in_s2 = st.in_s1;
      next_st.io_s1 = input_only_pin_in; // [RULE13]
      next_st.io_s2 = st.io_s1;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st <= '0;
         st.lock <= rops_pkg::ROPS_LOCKED;
         st.sel <= {NUM_PINS{`ROPS_SEL_RESET}}; // [RULE2]
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   // Input-only pins have no output path at all.
   assign pin_out = st.out;
   assign pin_oe = st.oe; // [RULE13]
   assign pin_in_sync = st.in_s2;
   assign input_only_in_sync = st.io_s2;
   assign sel_readback = st.sel;
   assign unlocked = (st.lock == rops_pkg::ROPS_OPEN);
   assign write_rejected = st.rejected;

   // ==========================================================
   // Checks
   a_lock_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.lock != rops_pkg::ROPS_OPEN) |=> $stable(st.sel)) // [RULE20]
      else $error("selector changed while locked");
   a_analog_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      analog_sel[0] |=> !pin_oe[0]) // [RULE11]
      else $error("pin driven while analog selected");
   a_remap_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!analog_sel[0] && mux_valid[0]) |=>
      (pin_oe[0] && pin_out[0] == $past(mux_level[0]))) // [RULE10]
      else $error("remap did not drive pin");
   a_default_path: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!analog_sel[0] && !mux_valid[0]) |=>
      (pin_oe[0] == $past(default_valid[0]))) // [RULE15]
      else $error("default function lost");
   a_null_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.sel[0] == `ROPS_CODE_NULL) |-> !mux_valid[0]) // [RULE2]
      else $error("null code drives pin");
   a_refclk_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.sel[0] == `ROPS_CODE_REFCLK && !analog_sel[0]) |=>
      (pin_out[0] == $past(periph.reference_clock_out))) // [RULE9]
      else $error("reference clock not routed");
   a_unlock_seq: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.lock == rops_pkg::ROPS_LOCKED && key_valid &&
      key_data == `ROPS_KEY1) ##1 (key_valid && key_data == `ROPS_KEY2)
      |=> unlocked) // [RULE20]
      else $error("unlock sequence failed");
   a_write_lands: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (unlocked && sel_write && sel_index == 8'h00) |=>
      (st.sel[0] == $past(sel_data))) // [RULE1]
      else $error("open write did not land");
   a_reject_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!unlocked && sel_write) |=> write_rejected) // [RULE17]
      else $error("locked write not flagged");

   // ==========================================================
   // Lock sequencing checks
   // A wrong second key must drop the gate back to fully locked, so a
   // stray 0x55 left over from an aborted sequence cannot be reused.
   a_half_relocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.lock == rops_pkg::ROPS_HALF && key_valid &&
      key_data != `ROPS_KEY2) |=>
      (st.lock == rops_pkg::ROPS_LOCKED)) // [RULE20]
      else $error("wrong second key did not relock");
   // The correct second key opens the gate on the very next cycle.
   a_half_opens: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.lock == rops_pkg::ROPS_HALF && key_valid &&
      key_data == `ROPS_KEY2) |=> unlocked) // [RULE20]
      else $error("second key did not open the gate");
   // A relock request shuts the gate at once.
   a_relock_req: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (unlocked && lock_req) |=> !unlocked) // [RULE17]
      else $error("relock request ignored");
   // The lock state stays one-hot, so a glitched code cannot look open.
   a_lock_onehot: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $onehot(st.lock)) // [RULE17]
      else $error("lock state not one-hot");

   // ==========================================================
   // Write path checks
   // The refusal flag is a pulse tied to a write; it never fires alone.
   a_reject_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !sel_write |=> !write_rejected) // [RULE20]
      else $error("refusal flagged without a write");
   // An index past the last pin is refused even while the gate is open.
   a_bad_index: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sel_write && int'(sel_index) >= NUM_PINS) |=>
      write_rejected) // [RULE17]
      else $error("out of range index not refused");
   // A legal open write is never refused, whatever code it carries.
   a_open_accept: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (unlocked && sel_write && int'(sel_index) < NUM_PINS) |=>
      !write_rejected) // [RULE12]
      else $error("legal open write refused");
   // Without a write strobe no selector may move.
   a_sel_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !sel_write |=> $stable(st.sel)) // [RULE1]
      else $error("selector moved without a write");
   // A reset leaves every selector at the null code and the gate shut.
   a_rst_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(sys_rst) |-> (sel_readback == '0 && !unlocked)) // [RULE2]
      else $error("reset left state behind");
   // An unassigned code behaves as the null code.
   a_spare_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st.sel[0] == 6'h02 || st.sel[0] == 6'h3f) |->
      !mux_valid[0]) // [RULE19]
      else $error("unassigned code drives pin");

   // ==========================================================
   // Input synchroniser checks
   // Each pin input reaches the input routing two clocks after it is
   // sampled; a shorter path would let metastability through.
   a_in_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!$past(sys_rst) && !$past(sys_rst, 2)) |->
      (pin_in_sync == $past(pin_in, 2))) // [RULE16]
      else $error("pin input synchroniser depth wrong");
   // Input-only pins take the same two-stage path and nothing else.
   a_io_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!$past(sys_rst) && !$past(sys_rst, 2)) |->
      (input_only_in_sync == $past(input_only_pin_in, 2))) // [RULE13]
      else $error("input-only synchroniser depth wrong");

   // ==========================================================
   // Per-pin priority checks
   // The same priority holds on every pin, not only on the first one.
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_chk
      // An analog pin is left fully quiet by the digital side.
      a_analog_quiet: assert property (@(posedge ref_clk)
         disable iff (sys_rst)
         analog_sel[p] |=> (!pin_oe[p] && !pin_out[p])) // [RULE11]
         else $error("analog pin driven");
      // A live remap drives the pin with the chosen peripheral level.
      a_remap_pin: assert property (@(posedge ref_clk)
         disable iff (sys_rst)
         (!analog_sel[p] && mux_valid[p]) |=>
         (pin_oe[p] && pin_out[p] == $past(mux_level[p]))) // [RULE10]
         else $error("remap lost on pin");
      // Without a remap the default function keeps the pin; its level
      // is masked so an idle default never leaves a stray high behind.
      a_default_pin: assert property (@(posedge ref_clk)
         disable iff (sys_rst)
         (!analog_sel[p] && !mux_valid[p]) |=>
         (pin_oe[p] == $past(default_valid[p]) &&
         pin_out[p] == ($past(default_level[p]) &&
         $past(default_valid[p])))) // [RULE15]
         else $error("default function lost on pin");
      // The null code never produces a remapped driver.
      a_null_pin: assert property (@(posedge ref_clk)
         disable iff (sys_rst)
         (st.sel[p] == `ROPS_CODE_NULL) |-> !mux_valid[p]) // [RULE2]
         else $error("null code drives pin");
   end
endmodule

// file: dv/rops_periph_model.sv
// Peripheral output model that feeds the crossbar.
`timescale 1ns/1ps
module rops_periph_model (
   input wire logic ref_clk,
   input wire logic [16:0] pattern,
   output rops_pkg::rops_periph_t periph
);
   // Peripheral levels launch from flops on the same clock, so they change
   // only just after a rising edge, never mid-cycle.
   always_ff @(posedge ref_clk) begin
      periph <= pattern;
   end
endmodule

// file: dv/rops_top_tb_top.sv
// Self-checking bench for the remappable output pin select block.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
   err_count++; $display("CHECK FAILED t=%0t got %h exp %h", \
   $time, got, exp); end end
module rops_top_tb_top;
   // ==========================================================
   // Stimulus and observation signals
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic key_valid = 1'b0;
   logic [7:0] key_data = 8'h00;
   logic lock_req = 1'b0;
   logic sel_write = 1'b0;
   logic [7:0] sel_index = 8'h00;
   logic [5:0] sel_data = 6'h00;
   logic [16:0] pattern = 17'h0_0000;
   logic [7:0] default_valid = 8'h00;
   logic [7:0] default_level = 8'h00;
   logic [7:0] analog_sel = 8'h00;
   logic [7:0] pin_in = 8'h00;
   logic [3:0] input_only_pin_in = 4'h0;
   rops_pkg::rops_periph_t periph;
   logic [7:0] pin_out, pin_oe, pin_in_sync;
   logic [3:0] input_only_in_sync;
   logic [47:0] sel_readback;
   logic unlocked, write_rejected;
   int err_count = 0;
   int n_tests = 0;
   int n_rej = 0;
   int p;
   logic [5:0] codes [17] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h18, 6'h19, 6'h1a, 6'h32, 6'h2d,
      6'h2f, 6'h31};
   // Bit of the peripheral struct that each code above must select.
   int srcs [17] = '{16, 15, 14, 13, 12, 11, 7, 8, 9, 10, 3, 4, 5, 6, 2,
      1, 0};
   logic [5:0] spare [3] = '{6'h00, 6'h02, 6'h3f};
   // ==========================================================
   // Clock, partner and design
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   rops_periph_model rops_periph_model_inst (.ref_clk(ref_clk),
      .pattern(pattern), .periph(periph));
   rops_top #(.NUM_PINS(8), .NUM_INPUT_ONLY(4)) rops_top_inst (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .key_valid(key_valid),
      .key_data(key_data), .lock_req(lock_req), .sel_write(sel_write),
      .sel_index(sel_index), .sel_data(sel_data), .periph(periph),
      .default_valid(default_valid), .default_level(default_level),
      .analog_sel(analog_sel), .pin_in(pin_in),
      .input_only_pin_in(input_only_pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in_sync(pin_in_sync),
      .input_only_in_sync(input_only_in_sync),
      .sel_readback(sel_readback), .unlocked(unlocked),
      .write_rejected(write_rejected));
   // Count refusal pulses so a doubled or missing pulse is seen.
   always @(posedge ref_clk) begin
      if (write_rejected === 1'b1) begin
         n_rej++;
      end
   end
   // ==========================================================
   // Access tasks
   task automatic key(input logic [7:0] k);
      @(negedge ref_clk);
      key_valid = 1'b1;
      key_data = k;
      @(negedge ref_clk);
      key_valid = 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [5:0] d);
      @(negedge ref_clk);
      sel_write = 1'b1;
      sel_index = idx;
      sel_data = d;
      @(negedge ref_clk);
      sel_write = 1'b0;
   endtask
   // Four cycles cover the two-cycle selector-to-pin path with margin.
   task automatic settle;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic look(input int q, input logic oe, input logic lv);
      settle;
      `CHK(pin_oe[q], oe)
      `CHK(pin_out[q], lv)
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      sys_rst = 1'b0;
      settle;
      `CHK(sel_readback, 48'h0000_0000_0000)
      `CHK(pin_oe, 8'h00)
      wr(8'h00, 6'h31);
      settle;
      `CHK(sel_readback, 48'h0000_0000_0000)
      `CHK(n_rej, 1)
      // A foreign key between the pair must keep the lock shut.
      key(8'h55);
      key(8'h12);
      key(8'haa);
      settle;
      `CHK(unlocked, 1'b0)
      key(8'h55);
      key(8'haa);
      for (int i = 0; i < 8 && unlocked !== 1'b1; i++) begin
         @(negedge ref_clk);
      end
      if (unlocked !== 1'b1) begin
         err_count++;
         end_sim;
      end
      default_valid = 8'hff;
      default_level = 8'hff;
      // Each code alone high, then alone low against a high default.
      for (int i = 0; i < 17; i++) begin
         p = i % 8;
         wr(p[7:0], codes[i]);
         settle;
         `CHK(sel_readback[6*p +: 6], codes[i])
         pattern = 17'h0_0001 << srcs[i];
         look(p, 1'b1, 1'b1);
         pattern = ~(17'h0_0001 << srcs[i]);
         look(p, 1'b1, 1'b0);
      end
      wr(8'h01, 6'h31);
      pattern = 17'h0_0001;
      look(0, 1'b1, 1'b1);
      look(1, 1'b1, 1'b1);
      analog_sel = 8'h01;
      settle;
      `CHK(pin_oe[0], 1'b0)
      `CHK(pin_out[0], 1'b0)
      analog_sel = 8'h00;
      // Null and unassigned codes fall back to the default function.
      pattern = 17'h1_ffff;
      for (int i = 0; i < 3; i++) begin
         wr(8'h02, spare[i]);
         default_level = 8'h00;
         look(2, 1'b1, 1'b0);
         default_level = 8'hff;
         look(2, 1'b1, 1'b1);
      end
      default_valid = 8'h00;
      look(2, 1'b0, 1'b0);
      wr(8'h08, 6'h01);
      settle;
      `CHK(n_rej, 2)
      @(negedge ref_clk);
      lock_req = 1'b1;
      @(negedge ref_clk);
      lock_req = 1'b0;
      wr(8'h00, 6'h01);
      settle;
      `CHK(sel_readback[5:0], 6'h31)
      `CHK(n_rej, 3)
      pin_in = 8'ha5;
      input_only_pin_in = 4'h6;
      settle;
      `CHK(pin_in_sync, 8'ha5)
      `CHK(input_only_in_sync, 4'h6)
      // A second reset in mid-run must clear selectors and relock.
      sys_rst = 1'b1;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      settle;
      `CHK(sel_readback, 48'h0000_0000_0000)
      `CHK(unlocked, 1'b0)
      end_sim;
   end
endmodule
